// [include/ext_bus_consts.svh]
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

// Register byte offsets on the configuration bus.
`define REG_CONFIG_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_ZONE_A_TIMING_OFS 8'h08
`define REG_ZONE_B_TIMING_OFS 8'h0C
`define REG_ZONE_C_TIMING_OFS 8'h10

// Configuration register fields.
`define CFG_DIVIDE_BIT 0
`define CFG_RESET 1'h0

// Status register fields.
`define STAT_HOLD_GRANTED_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_HOLD_REQUEST_BIT 2

// Zone timing register fields and reset value (lead 3, active 7, trail 3, ready ignored, 16-bit).
`define TIM_WIDTH 10
`define TIM_LEAD_MSB 1
`define TIM_LEAD_LSB 0
`define TIM_ACTIVE_MSB 4
`define TIM_ACTIVE_LSB 2
`define TIM_TRAIL_MSB 6
`define TIM_TRAIL_LSB 5
`define TIM_READY_MSB 8
`define TIM_READY_LSB 7
`define TIM_WIDE_BIT 9
`define TIM_RESET 10'h07F

// Ready sampling points, as timing-clock cycles left in the active phase including the current one.
`define READY_SYNC_POINT 3'h2
`define READY_ASYNC_POINT 3'h4

`endif

// [include/ext_bus_pkg.sv]
package ext_bus_pkg;

   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_ALIGN = 6'h02,
      ST_LEAD = 6'h04,
      ST_ACTIVE = 6'h08,
      ST_TRAIL = 6'h10,
      ST_HOLD = 6'h20
   } bus_state_t;

   typedef enum logic [1:0]
   {
      READY_IGNORE = 2'h0,
      READY_SYNC = 2'h1,
      READY_ASYNC = 2'h2
   } ready_mode_t;

   typedef struct packed
   {
      logic wide;
      logic [1:0] ready_mode;
      logic [1:0] trail;
      logic [2:0] active;
      logic [1:0] lead;
   } zone_timing_t;

   typedef struct packed
   {
      logic [1:0] zone;
      logic write;
      logic [1:0] lanes;
      logic [31:0] addr;
      logic [31:0] wdata;
   } access_req_t;

endpackage : ext_bus_pkg

// [verilog/external_bus_unit.sv]
// Functional notes
// RL1 - Data bus is 32 bits wide; 16-bit mode uses only the lower sixteen lines. Writes in 16-bit mode still drive all 32 lines.
// RL2 - Address is driven at a bus clock rising edge and held until the next access.
// RL3 - Shared low pin is address bit 0 in 16-bit mode, upper write strobe in 32-bit.
// RL4 - Bus clock comes from the timing clock, same rate or halved; same rate after reset.
// RL5 - In 16-bit mode the lower write strobe goes low for every write, shaped per zone.
// RL6 - Read strobe goes low for every read, shaped per zone by lead, active, trail.
// RL7 - Read strobe and lower write strobe are never low together.
// RL8 - Read-not-write is high for reads, low for writes, and rests high.
// RL9 - Each zone select is active only during an access to its own zone.
// RL10 - Each zone samples ready synchronously, asynchronously, or ignores it.
// RL11 - Synchronous ready is sampled one timing cycle before the active phase ends.
// RL12 - Asynchronous ready is sampled three timing cycles before the active phase ends.
// RL13 - Ready low at its sample adds one active cycle and resamples on the next edge.
// RL14 - Ready is sampled at the timing-clock rate whatever the bus clock division.
// RL15 - A hold request releases all pins only after the current access, with none pending.
// RL16 - The hold request is synchronised into the timing clock domain before use.
// RL17 - Hold acknowledge goes low when the bus is released, high once hold is withdrawn.
// RL18 - The external master drives the bus only while hold acknowledge is low.
// RL19 - In divided clock mode an alignment cycle makes accesses start on a rising edge.
// RL20 - Accesses run lead, active, trail; strobes only in active, select spans the access.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`include "ext_bus_consts.svh"

module external_bus_unit
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Avalon-MM configuration slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Access request port
   input wire logic i_acc_valid,
   input wire ext_bus_pkg::access_req_t i_acc,
   output logic o_acc_ready,
   output logic [31:0] o_acc_rdata,
   output logic o_acc_rdata_valid,
   // External data bus
   input wire logic [31:0] i_ext_data_bus,
   output logic [31:0] o_ext_data_bus,
   output logic o_ext_data_bus_oe_n,
   // External address, strobes and clock
   output logic [31:1] o_ext_address_bus,
   output logic o_low_address_bit_upper_write_strobe_n,
   output logic o_lower_write_strobe_n,
   output logic o_read_strobe_n,
   output logic o_read_not_write,
   output logic o_bus_output_clock,
   output logic o_bus_pins_oe_n,
   // Zone selects
   output logic o_zone_a_select_n,
   output logic o_zone_b_select_n,
   output logic o_zone_c_select_n,
   // Ready and hold handshakes
   input wire logic i_peripheral_ready,
   input wire logic i_bus_hold_request_n,
   output logic o_bus_hold_ack_n
);
   import ext_bus_pkg::*;

   logic output_clock_divide_select;
   zone_timing_t zone_timing_register [0:2];
   logic tick_phase;
   logic tick;
   logic hold_meta_n;
   logic hold_sync_n;
   logic hold_req;
   bus_state_t state;
   access_req_t cur;
   zone_timing_t cur_tim;
   logic [2:0] cnt;
   logic take;
   logic [31:0] next_readdata;
   logic [3:0] upd_lanes;

   function automatic logic [2:0] phase_len(input logic [2:0] val);
      // A programmed zero would make a phase vanish, so it runs as one cycle.
      phase_len = (val == 3'h0) ? 3'h1 : val;
   endfunction : phase_len

   function automatic zone_timing_t merge_timing(input zone_timing_t old, input logic [31:0] wd,
                                                 input logic [3:0] be);
      logic [`TIM_WIDTH-1:0] res;
      res = old;
      if (be[0])
      begin
         res[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         res[`TIM_WIDTH-1:8] = wd[`TIM_WIDTH-1:8];
      end
      merge_timing = res;
   endfunction : merge_timing

   // The internal timing clock is a one-cycle enable at half the reference rate.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         tick_phase <= 1'b0;
      end
      else
      begin
         tick_phase <= ~tick_phase;
      end
   end

   assign tick = tick_phase;

   // The bus clock rises at the same edge as each timing tick; halved mode toggles on ticks only.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_bus_output_clock <= 1'b0;
      end
      else if (!output_clock_divide_select)
      begin
         o_bus_output_clock <= tick_phase; // RL4
      end
      else if (tick)
      begin
         o_bus_output_clock <= ~o_bus_output_clock; // RL4
      end
   end

   // Hold request synchroniser.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         hold_meta_n <= 1'b1;
         hold_sync_n <= 1'b1;
      end
      else
      begin
         hold_meta_n <= i_bus_hold_request_n; // RL16
         hold_sync_n <= hold_meta_n; // RL16
      end
   end

   assign hold_req = ~hold_sync_n;

   // Requests are offered only in the cycle that ends with a timing tick, while idle.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_acc_ready <= 1'b0;
      end
      else
      begin
         o_acc_ready <= !tick_phase && (state == ST_IDLE) && !hold_req; // RL15
      end
   end

   assign take = i_acc_valid && o_acc_ready;

   // Access sequencer.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         state <= ST_IDLE;
         cur <= '0;
         cur_tim <= zone_timing_t'(`TIM_RESET);
         cnt <= 3'h0;
         o_ext_address_bus <= '0;
         o_low_address_bit_upper_write_strobe_n <= 1'b0;
         o_lower_write_strobe_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_read_not_write <= 1'b1;
         o_ext_data_bus <= '0;
         o_ext_data_bus_oe_n <= 1'b1;
         o_bus_pins_oe_n <= 1'b0;
         o_bus_hold_ack_n <= 1'b1;
         o_zone_a_select_n <= 1'b1;
         o_zone_b_select_n <= 1'b1;
         o_zone_c_select_n <= 1'b1;
         o_acc_rdata <= '0;
         o_acc_rdata_valid <= 1'b0;
      end
      else
      begin
         o_acc_rdata_valid <= 1'b0;
         if (tick)
         begin
            case (state)
               ST_IDLE:
               begin
                  if (take)
                  begin
                     cur <= i_acc;
                     cur_tim <= zone_timing_register[(i_acc.zone == 2'h3) ? 2'h2 : i_acc.zone];
                     // A halved bus clock that is already high would make this edge a falling one.
                     if (output_clock_divide_select && o_bus_output_clock)
                     begin
                        state <= ST_ALIGN; // RL19
                     end
                     else
                     begin
                        state <= ST_LEAD;
                     end
                  end
                  else if (hold_req)
                  begin
                     o_bus_pins_oe_n <= 1'b1; // RL15
                     o_ext_data_bus_oe_n <= 1'b1; // RL15
                     state <= ST_HOLD;
                  end
               end
               ST_ALIGN:
               begin
                  state <= ST_LEAD; // RL19
               end
               ST_LEAD:
               begin
                  if (cnt == 3'h1)
                  begin
                     cnt <= phase_len(cur_tim.active);
                     o_read_strobe_n <= cur.write; // RL6 RL7
                     if (cur.write)
                     begin
                        o_lower_write_strobe_n <= cur_tim.wide ? ~cur.lanes[0] : 1'b0; // RL5 RL7
                        if (cur_tim.wide)
                        begin
                           o_low_address_bit_upper_write_strobe_n <= ~cur.lanes[1]; // RL3
                        end
                     end
                     state <= ST_ACTIVE; // RL20
                  end
                  else
                  begin
                     cnt <= cnt - 3'h1;
                  end
               end
               ST_ACTIVE:
               begin
                  // A low ready at the sample point freezes the count, adding one cycle per low sample.
                  if ((ready_mode_t'(cur_tim.ready_mode) == READY_SYNC) && (cnt == `READY_SYNC_POINT) &&
                      !i_peripheral_ready)
                  begin
                     cnt <= cnt; // RL10 RL11 RL13 RL14
                  end
                  else if ((ready_mode_t'(cur_tim.ready_mode) == READY_ASYNC) && (cnt == `READY_ASYNC_POINT) &&
                           !i_peripheral_ready)
                  begin
                     cnt <= cnt; // RL10 RL12 RL13 RL14
                  end
                  else if (cnt == 3'h1)
                  begin
                     cnt <= phase_len({1'b0, cur_tim.trail});
                     o_read_strobe_n <= 1'b1; // RL20
                     o_lower_write_strobe_n <= 1'b1; // RL20
                     if (cur_tim.wide)
                     begin
                        o_low_address_bit_upper_write_strobe_n <= 1'b1; // RL3
                     end
                     if (!cur.write)
                     begin
                        o_acc_rdata <= cur_tim.wide ? i_ext_data_bus : {16'h0000, i_ext_data_bus[15:0]}; // RL1
                        o_acc_rdata_valid <= 1'b1;
                     end
                     state <= ST_TRAIL; // RL20
                  end
                  else
                  begin
                     cnt <= cnt - 3'h1;
                  end
               end
               ST_TRAIL:
               begin
                  if (cnt == 3'h1)
                  begin
                     o_zone_a_select_n <= 1'b1; // RL9
                     o_zone_b_select_n <= 1'b1; // RL9
                     o_zone_c_select_n <= 1'b1; // RL9
                     o_read_not_write <= 1'b1; // RL8
                     o_ext_data_bus_oe_n <= 1'b1;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     cnt <= cnt - 3'h1;
                  end
               end
               ST_HOLD:
               begin
                  if (!hold_req)
                  begin
                     o_bus_hold_ack_n <= 1'b1; // RL17
                     o_bus_pins_oe_n <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     o_bus_hold_ack_n <= 1'b0; // RL17 RL18
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
            // Entry into the lead phase: address, select, direction and write data all launch here.
            if (((state == ST_IDLE) && take && !(output_clock_divide_select && o_bus_output_clock)) ||
                (state == ST_ALIGN))
            begin
               if (state == ST_IDLE)
               begin
                  o_ext_address_bus <= i_acc.addr[31:1]; // RL2
                  o_low_address_bit_upper_write_strobe_n <=
                     zone_timing_register[(i_acc.zone == 2'h3) ? 2'h2 : i_acc.zone].wide ? 1'b1 : i_acc.addr[0]; // RL3
                  o_read_not_write <= ~i_acc.write; // RL8
                  o_zone_a_select_n <= (i_acc.zone != 2'h0); // RL9
                  o_zone_b_select_n <= (i_acc.zone != 2'h1); // RL9
                  o_zone_c_select_n <= (i_acc.zone != 2'h2); // RL9
                  o_ext_data_bus <= i_acc.wdata; // RL1
                  o_ext_data_bus_oe_n <= ~i_acc.write;
                  cnt <= phase_len({1'b0, zone_timing_register[(i_acc.zone == 2'h3) ? 2'h2 : i_acc.zone].lead});
               end
               else
               begin
                  o_ext_address_bus <= cur.addr[31:1]; // RL2
                  o_low_address_bit_upper_write_strobe_n <= cur_tim.wide ? 1'b1 : cur.addr[0]; // RL3
                  o_read_not_write <= ~cur.write; // RL8
                  o_zone_a_select_n <= (cur.zone != 2'h0); // RL9
                  o_zone_b_select_n <= (cur.zone != 2'h1); // RL9
                  o_zone_c_select_n <= (cur.zone != 2'h2); // RL9
                  o_ext_data_bus <= cur.wdata; // RL1
                  o_ext_data_bus_oe_n <= ~cur.write;
                  cnt <= phase_len({1'b0, cur_tim.lead});
               end
            end
         end
      end
   end

   // Register writes take effect at the edge where waitrequest is seen low.
   assign upd_lanes = (i_avs_write && !o_avs_waitrequest) ? i_avs_byteenable : 4'h0;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         output_clock_divide_select <= `CFG_RESET; // RL4
         zone_timing_register[0] <= zone_timing_t'(`TIM_RESET);
         zone_timing_register[1] <= zone_timing_t'(`TIM_RESET);
         zone_timing_register[2] <= zone_timing_t'(`TIM_RESET);
      end
      else if (i_avs_address == `REG_CONFIG_OFS)
      begin
         if (upd_lanes[0])
         begin
            output_clock_divide_select <= i_avs_writedata[`CFG_DIVIDE_BIT]; // RL4
         end
      end
      else if (i_avs_address == `REG_ZONE_A_TIMING_OFS)
      begin
         zone_timing_register[0] <= merge_timing(zone_timing_register[0], i_avs_writedata, upd_lanes);
      end
      else if (i_avs_address == `REG_ZONE_B_TIMING_OFS)
      begin
         zone_timing_register[1] <= merge_timing(zone_timing_register[1], i_avs_writedata, upd_lanes);
      end
      else if (i_avs_address == `REG_ZONE_C_TIMING_OFS)
      begin
         zone_timing_register[2] <= merge_timing(zone_timing_register[2], i_avs_writedata, upd_lanes);
      end
   end

   always_comb
   begin
      next_readdata = 32'h00000000;
      if (i_avs_address == `REG_CONFIG_OFS)
      begin
         next_readdata[`CFG_DIVIDE_BIT] = output_clock_divide_select;
      end
      else if (i_avs_address == `REG_STATUS_OFS)
      begin
         next_readdata[`STAT_HOLD_GRANTED_BIT] = ~o_bus_hold_ack_n;
         next_readdata[`STAT_BUSY_BIT] = (state != ST_IDLE) && (state != ST_HOLD);
         next_readdata[`STAT_HOLD_REQUEST_BIT] = hold_req;
      end
      else if (i_avs_address == `REG_ZONE_A_TIMING_OFS)
      begin
         next_readdata[`TIM_WIDTH-1:0] = zone_timing_register[0];
      end
      else if (i_avs_address == `REG_ZONE_B_TIMING_OFS)
      begin
         next_readdata[`TIM_WIDTH-1:0] = zone_timing_register[1];
      end
      else if (i_avs_address == `REG_ZONE_C_TIMING_OFS)
      begin
         next_readdata[`TIM_WIDTH-1:0] = zone_timing_register[2];
      end
   end

   // Every access is answered one cycle after it is presented; unmapped offsets read zero.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end
      else if (o_avs_waitrequest && (i_avs_read || i_avs_write))
      begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata <= next_readdata;
      end
      else
      begin
         o_avs_waitrequest <= 1'b1;
      end
   end

endmodule : external_bus_unit

// [verif/external_bus_unit_checker.sv]
`timescale 1ns/100ps
module external_bus_unit_checker
(
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Watched pins
   input wire logic i_bus_hold_request_n,
   input wire logic o_ext_data_bus_oe_n,
   input wire logic [31:1] o_ext_address_bus,
   input wire logic o_lower_write_strobe_n,
   input wire logic o_read_strobe_n,
   input wire logic o_read_not_write,
   input wire logic o_bus_output_clock,
   input wire logic o_bus_pins_oe_n,
   input wire logic o_zone_a_select_n,
   input wire logic o_zone_b_select_n,
   input wire logic o_zone_c_select_n,
   input wire logic o_bus_hold_ack_n
);
   logic sel;
   assign sel = !(o_zone_a_select_n && o_zone_b_select_n && o_zone_c_select_n);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   property p_excl; !(!o_read_strobe_n && !o_lower_write_strobe_n); endproperty
   property p_rd_rnw; !o_read_strobe_n |-> o_read_not_write; endproperty
   property p_wr_rnw; !o_lower_write_strobe_n |-> !o_read_not_write; endproperty
   property p_one_sel; $onehot0({!o_zone_a_select_n, !o_zone_b_select_n, !o_zone_c_select_n}); endproperty
   property p_strobe_sel; (!o_read_strobe_n || !o_lower_write_strobe_n) |-> sel; endproperty
   property p_addr_edge; $changed(o_ext_address_bus) |-> $rose(o_bus_output_clock); endproperty
   property p_drive_wr; !o_ext_data_bus_oe_n |-> !o_read_not_write; endproperty
   property p_ack_rel; $fell(o_bus_hold_ack_n) |-> o_bus_pins_oe_n && o_ext_data_bus_oe_n && !sel; endproperty
   property p_hold_sync; $fell(i_bus_hold_request_n) |-> o_bus_hold_ack_n [*3]; endproperty
   property p_ack_drop; $rose(i_bus_hold_request_n) |-> ##[1:8] o_bus_hold_ack_n; endproperty
   property p_hold_idle; !o_bus_hold_ack_n |-> o_bus_pins_oe_n && o_read_strobe_n && o_lower_write_strobe_n; endproperty
   a_excl: assert property (p_excl)
      else $error("strobes overlap");
   a_rd_rnw: assert property (p_rd_rnw)
      else $error("read direction");
   a_wr_rnw: assert property (p_wr_rnw)
      else $error("write direction");
   a_one_sel: assert property (p_one_sel)
      else $error("two selects");
   a_strobe_sel: assert property (p_strobe_sel)
      else $error("strobe unselected");
   a_addr_edge: assert property (p_addr_edge)
      else $error("address off clock edge");
   a_drive_wr: assert property (p_drive_wr)
      else $error("data driven on read");
   a_ack_rel: assert property (p_ack_rel)
      else $error("grant while driving");
   a_hold_sync: assert property (p_hold_sync)
      else $error("early grant");
   a_ack_drop: assert property (p_ack_drop)
      else $error("late release");
   a_hold_idle: assert property (p_hold_idle)
      else $error("activity in hold");
   c_read: cover property ($fell(o_read_strobe_n));
   c_write: cover property ($fell(o_lower_write_strobe_n));
   c_hold: cover property ($fell(o_bus_hold_ack_n));
endmodule : external_bus_unit_checker

bind external_bus_unit external_bus_unit_checker chk_u (.*);

// [verif/ext_peripheral_model.sv]
`timescale 1ns/100ps
module ext_peripheral_model
(
   // Clock
   input wire logic i_ref_clk,
   // Device pins
   input wire logic [31:1] i_addr,
   input wire logic i_read_strobe_n,
   input wire logic i_bus_hold_ack_n,
   // Bench controls
   input wire logic [7:0] i_stall,
   input wire logic i_hold,
   // Driven back
   output logic [31:0] o_data,
   output logic o_ready,
   output logic o_hold_request_n
);
   logic [31:0] last = 32'h0;
   logic [7:0] cnt = 8'h00;
   always_ff @(posedge i_ref_clk)
   begin
      cnt <= i_read_strobe_n ? 8'h00 : cnt + 8'h01;
      if (!i_read_strobe_n)
         last <= o_data;
   end
   // Idle lines show the inverse of the last word, so stale captures fail.
   assign o_data = (!i_read_strobe_n && i_bus_hold_ack_n) ? {i_addr[16:1], ~i_addr[16:1]} : ~last;
   // Ready is low for the first i_stall strobe cycles.
   assign o_ready = (cnt >= i_stall);
   assign o_hold_request_n = !i_hold;
endmodule : ext_peripheral_model

// [verif/external_bus_unit_tb.sv]
`timescale 1ns/100ps
`include "ext_bus_consts.svh"
module external_bus_unit_tb;
   import ext_bus_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic i_acc_valid = 1'b0;
   access_req_t i_acc = '0;
   logic [31:0] o_avs_readdata, o_acc_rdata, i_ext_data_bus, o_ext_data_bus, rd, st_dout;
   logic [31:1] o_ext_address_bus;
   logic o_avs_waitrequest, o_acc_ready, o_acc_rdata_valid, o_ext_data_bus_oe_n, o_read_strobe_n;
   logic o_low_address_bit_upper_write_strobe_n, o_lower_write_strobe_n, o_read_not_write, o_bus_output_clock;
   logic o_bus_pins_oe_n, o_zone_a_select_n, o_zone_b_select_n, o_zone_c_select_n, o_bus_hold_ack_n;
   logic i_peripheral_ready, i_bus_hold_request_n, cur_wr, strb_n, sel_idle, st_up;
   logic [7:0] stall = 8'h00;
   logic hold = 1'b0;
   int n_errors = 0;
   int checks_done = 0;
   int ld, ac, tr, n, m;
   assign strb_n = cur_wr ? o_lower_write_strobe_n : o_read_strobe_n;
   assign sel_idle = o_zone_a_select_n & o_zone_b_select_n & o_zone_c_select_n;
   always #2 i_ref_clk = ~i_ref_clk;

   external_bus_unit dut_u (.*, .i_avs_byteenable(4'hF));
   ext_peripheral_model peer_u (.i_ref_clk, .i_addr(o_ext_address_bus), .i_read_strobe_n(o_read_strobe_n),
      .i_bus_hold_ack_n(o_bus_hold_ack_n), .i_stall(stall), .i_hold(hold), .o_data(i_ext_data_bus),
      .o_ready(i_peripheral_ready), .o_hold_request_n(i_bus_hold_request_n));

   task complete_run;
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task chk(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk

   // Every wait is bounded; running out ends the run as a failure.
   task automatic wait_lvl(ref logic s, input logic v, inout int cnt);
      int k;
      k = 0;
      do
      begin
         @(negedge i_ref_clk);
         cnt++;
         k++;
      end
      while (s !== v && k < 200);
      if (s !== v)
      begin
         n_errors++;
         $display("mismatch at %0t: wait bound ran out", $time);
         complete_run();
      end
   endtask : wait_lvl

   task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      int k;
      @(posedge i_ref_clk);
      i_avs_address <= a;
      i_avs_writedata <= wd;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      k = 0;
      wait_lvl(o_avs_waitrequest, 1'b0, k);
      @(posedge i_ref_clk);
      d = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask : av

   task automatic av_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      av(1'b0, a, 32'h0, d);
      chk(d === e, "register read");
   endtask : av_chk

   task automatic clk_chk(input int e);
      int t;
      logic p;
      t = 0;
      @(negedge i_ref_clk);
      p = o_bus_output_clock;
      repeat (8)
      begin
         @(negedge i_ref_clk);
         if (o_bus_output_clock !== p)
            t++;
         p = o_bus_output_clock;
      end
      chk(t == e, "bus clock rate");
   endtask : clk_chk

   task automatic run_acc(input logic [1:0] z, input logic w, input logic [1:0] ln, input logic [31:0] a,
      input logic [31:0] wd);
      int k;
      int j;
      @(posedge i_ref_clk);
      cur_wr <= w;
      i_acc <= '{zone: z, write: w, lanes: ln, addr: a, wdata: wd};
      i_acc_valid <= 1'b1;
      k = 0;
      wait_lvl(o_acc_ready, 1'b1, k);
      @(posedge i_ref_clk);
      i_acc_valid <= 1'b0;
      k = 0;
      wait_lvl(strb_n, 1'b0, k);
      ld = k - 1;
      st_up = o_low_address_bit_upper_write_strobe_n;
      st_dout = o_ext_data_bus;
      chk({o_zone_c_select_n, o_zone_b_select_n, o_zone_a_select_n} === ~(3'h1 << z), "zone select");
      chk(o_ext_address_bus === a[31:1], "address");
      chk(o_read_not_write === !w && o_ext_data_bus_oe_n === !w, "direction");
      j = k;
      wait_lvl(strb_n, 1'b1, k);
      ac = k - j;
      chk(o_acc_rdata_valid === !w, "read data pulse");
      j = k;
      wait_lvl(sel_idle, 1'b1, k);
      tr = k - j;
   endtask : run_acc

   initial
   begin
      repeat (6) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      av_chk(`REG_CONFIG_OFS, 32'h0);
      av_chk(`REG_ZONE_A_TIMING_OFS, 32'h7F);
      av_chk(8'h40, 32'h0);
      clk_chk(8);
      av(1'b1, `REG_ZONE_A_TIMING_OFS, 32'h4A, rd);
      av_chk(`REG_ZONE_A_TIMING_OFS, 32'h4A);
      av(1'b1, `REG_ZONE_B_TIMING_OFS, 32'h22D, rd);
      stall <= 8'h14;
      run_acc(2'h0, 1'b0, 2'h0, 32'h0001_2345, 32'h0);
      chk(ld == 4 && ac == 4 && tr == 4, "phase lengths with ready ignored");
      chk(o_acc_rdata === 32'h0000_6E5D && st_up === 1'b1, "narrow read");
      run_acc(2'h0, 1'b1, 2'h2, 32'h0000_0100, 32'hBEEF_1234);
      chk(st_dout[15:0] === 16'h1234 && st_up === 1'b0, "narrow write");
      run_acc(2'h1, 1'b1, 2'h3, 32'h0000_0200, 32'hCAFE_5678);
      chk(st_up === 1'b0 && st_dout === 32'hCAFE_5678 && ld == 2 && ac == 6 && tr == 2, "wide write");
      run_acc(2'h1, 1'b1, 2'h1, 32'h0000_0204, 32'h1357_9BDF);
      chk(st_up === 1'b1, "upper strobe idle for lower lane");
      run_acc(2'h1, 1'b0, 2'h0, 32'h0000_0ABC, 32'h0);
      chk(o_acc_rdata === 32'h055E_FAA1, "wide read");
      // Ready low only early in the active phase: the early sample extends, the late one does not.
      for (n = 0; n < 2; n++)
      begin
         av(1'b1, `REG_ZONE_C_TIMING_OFS, (n == 1) ? 32'h131 : 32'hB1, rd);
         stall <= 8'h03;
         run_acc(2'h2, 1'b0, 2'h0, 32'h0000_0300, 32'h0);
         chk((n == 1) ? (ac > 8 && ac <= 12) : (ac == 8), "ready sample point");
      end
      av(1'b1, `REG_ZONE_C_TIMING_OFS, 32'hB1, rd);
      stall <= 8'h14;
      run_acc(2'h2, 1'b0, 2'h0, 32'h0000_0304, 32'h0);
      chk(ac > 8 && ac <= 32, "wait extension");
      stall <= 8'h00;
      fork
         run_acc(2'h0, 1'b0, 2'h0, 32'h0000_0010, 32'h0);
         begin
            repeat (6) @(posedge i_ref_clk);
            hold <= 1'b1;
         end
      join
      chk(ld == 4 && ac == 4 && tr == 4, "access finished before hold");
      m = 0;
      wait_lvl(o_bus_hold_ack_n, 1'b0, m);
      chk(o_bus_pins_oe_n === 1'b1 && o_ext_data_bus_oe_n === 1'b1, "pins released");
      av(1'b0, `REG_STATUS_OFS, 32'h0, rd);
      chk(rd[`STAT_HOLD_GRANTED_BIT] === 1'b1, "hold status");
      i_acc_valid <= 1'b1;
      m = 0;
      repeat (8)
      begin
         @(negedge i_ref_clk);
         if (o_acc_ready !== 1'b0)
            m++;
      end
      chk(m == 0, "access refused in hold");
      @(posedge i_ref_clk);
      i_acc_valid <= 1'b0;
      hold <= 1'b0;
      m = 0;
      wait_lvl(o_bus_hold_ack_n, 1'b1, m);
      chk(o_bus_pins_oe_n === 1'b0, "pins driven again");
      av(1'b1, `REG_CONFIG_OFS, 32'h1, rd);
      clk_chk(4);
      run_acc(2'h0, 1'b0, 2'h0, 32'h0000_0020, 32'h0);
      chk(ac == 4 && tr == 4, "timing clock phases in divided mode");
      av(1'b1, `REG_CONFIG_OFS, 32'h0, rd);
      clk_chk(8);
      complete_run();
   end
endmodule : external_bus_unit_tb
